// file: dv/umac_sink.sv
// umac_sink: consumer model latching the narrow result like a 12-bit dac
`timescale 1ns/1ps
`default_nettype none
module umac_sink (
	// clock
	input wire logic clk,
	// from unit
	input wire logic valid,
	input wire logic [11:0] din,
	// latched code
	output logic [11:0] code
);
	// take a code only on a fresh result
	always_ff @(posedge clk) begin
		if (valid)
			code <= din;
	end
endmodule // umac_sink
`default_nettype wire

// file: dv/unsigned_mul_add_core_tb.sv
// unsigned_mul_add_core_tb: self-checking bench for the arithmetic unit
`timescale 1ns/1ps
`default_nettype none
module unsigned_mul_add_core_tb;
	import umac_pkg::*;
	logic clk = 1'h0, rst = 1'h1, subtract = 1'h0, eval = 1'h0, valid;
	umac_mode_e mode = UMAC_MODE_MUL;
	logic [4:0] mul_shift = 5'h0, add_shift = 5'h0;
	umac_word_t op_k = 16'h0, op_x = 16'h0, op_a = 16'h0, op_b = 16'h0;
	umac_word_t rnd = 16'h02e5, result;
	logic [11:0] result_narrow, code;
	umac_word_t exp_q[$];
	int err_count = 0, cmp_count = 0;
	always #5 clk = ~clk;
	unsigned_mul_add_core unsigned_mul_add_core_inst (.clk, .rst, .mode,
		.subtract, .mul_shift, .add_shift, .eval, .op_k, .op_x, .op_a,
		.op_b, .result, .result_narrow, .valid);
	umac_sink umac_sink_inst (.clk, .valid, .din(result_narrow), .code);
	task automatic chk(input umac_word_t s, input umac_word_t w, string t);
		cmp_count++;
		if (s !== w) begin
			err_count++;
			$display("BAD %0t %s got %h want %h", $time, t, s, w);
		end
	endtask
	function automatic umac_word_t nx();
		rnd = {rnd[14:0], rnd[15] ^ rnd[13] ^ rnd[12] ^ rnd[10]};
		return rnd;
	endfunction
	function automatic umac_word_t sat(input logic [32:0] v);
		return (v > 33'h0ffff) ? 16'hffff : v[15:0];
	endfunction
	function automatic logic [32:0] ad(logic s, umac_word_t a, umac_word_t b);
		if (s)
			return (a < b) ? 33'h0 : {17'h0, a} - {17'h0, b};
		return {17'h0, a} + {17'h0, b};
	endfunction
	function automatic umac_word_t model(umac_mode_e m, logic s,
		logic [4:0] ms, as, umac_word_t k, x, a, b);
		umac_word_t p;
		p = sat(({17'h0, k} * {17'h0, x}) >> ms);
		case (m)
			UMAC_MODE_MUL: return p;
			UMAC_MODE_ADD: return sat(ad(s, a, b) >> as);
			UMAC_MODE_MUL_ADD: return sat(ad(s, p, b));
			default: return sat(({17'h0, k} * {17'h0, sat(ad(s, a, b))}) >> ms);
		endcase
	endfunction
	task automatic op(umac_mode_e m, logic s, logic [4:0] ms, as,
		umac_word_t k, x, a, b);
		@(posedge clk);
		mode <= m;
		subtract <= s;
		mul_shift <= ms;
		add_shift <= as;
		{op_k, op_x, op_a, op_b} <= {k, x, a, b};
		eval <= 1'h1;
		if ($onehot(m))
			exp_q.push_back(model(m, s, ms, as, k, x, a, b));
	endtask
	// watcher: each result takes the oldest note
	always @(negedge clk) begin
		if (!rst && valid === 1'h1) begin
			if (exp_q.size() == 0)
				chk(16'h1, 16'h0, "stray valid");
			else begin
				chk(result, exp_q[0], "result");
				chk({4'h0, result_narrow}, {4'h0, exp_q[0][11:0]}, "low");
				void'(exp_q.pop_front());
			end
		end
	end
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		umac_word_t r;
		repeat (3) @(posedge clk);
		rst <= 1'h0;
		@(negedge clk);
		chk(result, 16'h0, "reset");
		op(UMAC_MODE_MUL, 1'h0, 5'h0c, 5'h0, 16'h2000, 16'h4000, 16'h0, 16'h0);
		op(UMAC_MODE_ADD, 1'h1, 5'h0, 5'h0, 16'h0, 16'h0, 16'h0005, 16'h0009);
		op(UMAC_MODE_MUL, 1'h0, 5'h0, 5'h0, 16'hffff, 16'hffff, 16'h0, 16'h0);
		op(UMAC_MODE_MUL_ADD, 1'h0, 5'h0, 5'h0, 16'h3, 16'h10, 16'h0, 16'h64);
		op(UMAC_MODE_ADD, 1'h0, 5'h0, 5'h01, 16'h0, 16'h0, 16'h00f0, 16'h0);
		op(umac_mode_e'(4'h3), 1'h0, 5'h0, 5'h0, 16'h1, 16'h1, 16'h1, 16'h1);
		repeat (3) @(posedge clk) eval <= 1'h0;
		@(negedge clk);
		chk(result, 16'h0078, "held");
		chk({4'h0, code}, 16'h0078, "sink");
		$display("directed test done");
		for (int i = 0; i < 64; i++) begin
			r = nx();
			op(umac_mode_e'(4'h1 << r[1:0]), r[2], r[7:3], r[12:8], nx(),
				nx(), nx(), nx());
		end
		@(posedge clk) eval <= 1'h0;
		for (int i = 0; i < 20 && exp_q.size() != 0; i++) @(posedge clk);
		chk(16'(exp_q.size()), 16'h0, "drain timeout");
		$display("random test done");
		tally_and_finish();
	end
endmodule // unsigned_mul_add_core_tb
`default_nettype wire

// file: verilog/umac_addsub.sv
// umac_addsub: adder/subtractor with saturation and zero clamp
`timescale 1ns/1ps
`default_nettype none
module umac_addsub (
	// stage link
	umac_stage_if.unit st
);
	import umac_pkg::*;
	wire logic [UMAC_W:0] sum;
	wire logic [UMAC_W:0] sum_sh;
	wire logic under;
	assign sum = {1'b0, st.op_a} + {1'b0, st.op_b};
	assign sum_sh = sum >> st.shift;
	assign under = st.op_a < st.op_b;
	assign st.result = st.sub ? (under ? UMAC_ZERO
		: umac_word_t'((st.op_a - st.op_b) >> st.shift))
		: (sum_sh[UMAC_W] ? UMAC_MAX : sum_sh[UMAC_W-1:0]);
endmodule // umac_addsub
`default_nettype wire

// file: verilog/umac_mul.sv
// umac_mul: multiplier with post shift and high saturation
`timescale 1ns/1ps
`default_nettype none
module umac_mul (
	// stage link
	umac_stage_if.unit st
);
	import umac_pkg::*;
	wire logic [UMAC_PW-1:0] prod;
	wire logic [UMAC_PW-1:0] shifted;
	wire logic over;
	assign prod = UMAC_PW'(st.op_a) * UMAC_PW'(st.op_b);
	assign shifted = prod >> st.shift;
	assign over = |shifted[UMAC_PW-1:UMAC_W];
	assign st.result = over ? UMAC_MAX : shifted[UMAC_W-1:0];
endmodule // umac_mul
`default_nettype wire

// file: verilog/umac_pkg.sv
// umac_pkg: shared constants and types for the arithmetic unit
`default_nettype none
package umac_pkg;
	localparam int UMAC_W = 16;
	localparam int UMAC_PW = 32;
	localparam int UMAC_SHW = 5;
	localparam int UMAC_NARROW_W = 12;
	localparam logic [UMAC_W-1:0] UMAC_MAX = 16'hffff;
	localparam logic [UMAC_W-1:0] UMAC_ZERO = 16'h0000;
	localparam logic [UMAC_SHW-1:0] UMAC_SH_NONE = 5'h00;

	// operating modes, one-hot
	typedef enum logic [3:0] {
		UMAC_MODE_MUL = 4'h1,
		UMAC_MODE_ADD = 4'h2,
		UMAC_MODE_MUL_ADD = 4'h4,
		UMAC_MODE_ADD_MUL = 4'h8
	} umac_mode_e;

	typedef logic [UMAC_W-1:0] umac_word_t;
endpackage
`default_nettype wire

// file: verilog/umac_stage_if.sv
// umac_stage_if: operand and result bundle between datapath stages
`timescale 1ns/1ps
`default_nettype none
interface umac_stage_if;
	import umac_pkg::*;
	umac_word_t op_a;
	umac_word_t op_b;
	logic [UMAC_SHW-1:0] shift;
	logic sub;
	umac_word_t result;
	modport user (output op_a, output op_b, output shift, output sub,
		input result);
	modport unit (input op_a, input op_b, input shift, input sub,
		output result);
endinterface
`default_nettype wire

// file: verilog/unsigned_mul_add_core.sv
// unsigned_mul_add_core: top of the registered arithmetic unit
`timescale 1ns/1ps
`default_nettype none
module unsigned_mul_add_core (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// configuration
	input wire umac_pkg::umac_mode_e mode,
	input wire logic subtract,
	input wire logic [umac_pkg::UMAC_SHW-1:0] mul_shift,
	input wire logic [umac_pkg::UMAC_SHW-1:0] add_shift,
	// operands
	input wire logic eval,
	input wire logic [umac_pkg::UMAC_W-1:0] op_k,
	input wire logic [umac_pkg::UMAC_W-1:0] op_x,
	input wire logic [umac_pkg::UMAC_W-1:0] op_a,
	input wire logic [umac_pkg::UMAC_W-1:0] op_b,
	// results
	output logic [umac_pkg::UMAC_W-1:0] result,
	output logic [umac_pkg::UMAC_NARROW_W-1:0] result_narrow,
	output logic valid
);
	import umac_pkg::*;

	umac_stage_if mul_if ();
	umac_stage_if add_if ();

	umac_word_t result_reg;
	umac_word_t result_next;
	logic valid_reg;
	wire logic is_mul;
	wire logic is_add;
	wire logic is_mul_add;
	wire logic is_add_mul;
	wire logic mode_ok;

	assign is_mul = mode == UMAC_MODE_MUL;
	assign is_add = mode == UMAC_MODE_ADD;
	assign is_mul_add = mode == UMAC_MODE_MUL_ADD;
	assign is_add_mul = mode == UMAC_MODE_ADD_MUL;
	assign mode_ok = is_mul | is_add | is_mul_add | is_add_mul;

	// multiplier stage
	assign mul_if.op_a = op_k;
	assign mul_if.op_b = is_add_mul ? add_if.result : op_x;
	assign mul_if.shift = mul_shift;
	assign mul_if.sub = 1'b0;
	// adder stage
	assign add_if.op_a = is_mul_add ? mul_if.result : op_a;
	assign add_if.op_b = op_b;
	assign add_if.shift = is_add ? add_shift : UMAC_SH_NONE;
	assign add_if.sub = subtract;

	umac_mul u_mul (
		.st(mul_if)
	);
	umac_addsub u_add (
		.st(add_if)
	);

	// final selection, saturation done in the stages
	assign result_next = (is_add | is_mul_add) ? add_if.result
		: ((is_mul | is_add_mul) ? mul_if.result : result_reg);

	always_ff @(posedge clk) begin
		if (rst) begin
			result_reg <= UMAC_ZERO;
			valid_reg <= 1'b0;
		end else if (eval && mode_ok) begin
			result_reg <= result_next;
			valid_reg <= 1'b1;
		end else begin
			valid_reg <= 1'b0;
		end
	end

	assign result = result_reg;
	assign result_narrow = result_reg[UMAC_NARROW_W-1:0];
	assign valid = valid_reg;

	// checks
	a_hold_idle: assert property (@(posedge clk) disable iff (rst)
		!eval |=> $stable(result))
		else $error("result changed without eval");
	a_mul_value: assert property (@(posedge clk) disable iff (rst)
		eval && is_mul && mul_shift == 5'h00 && op_k == 16'h0002
		&& op_x < 16'h8000 |=> result == $past(op_x) * 2)
		else $error("multiply result wrong");
	a_add_value: assert property (@(posedge clk) disable iff (rst)
		eval && is_add && !subtract && add_shift == 5'h00
		&& ({1'b0, op_a} + {1'b0, op_b}) <= 17'h0ffff
		|=> result == $past(op_a) + $past(op_b))
		else $error("sum wrong");
	a_sub_clamp: assert property (@(posedge clk) disable iff (rst)
		eval && is_add && subtract && op_a < op_b
		|=> result == 16'h0000)
		else $error("negative difference not clamped");
	a_add_sat: assert property (@(posedge clk) disable iff (rst)
		eval && is_add && !subtract && add_shift == 5'h00
		&& ({1'b0, op_a} + {1'b0, op_b}) > 17'h0ffff
		|=> result == 16'hffff)
		else $error("sum not saturated");
	a_mul_sat: assert property (@(posedge clk) disable iff (rst)
		eval && is_mul && mul_shift == 5'h00 && op_k > 16'h0001
		&& op_x == 16'hffff |=> result == 16'hffff)
		else $error("product not saturated");
	a_shift_half: assert property (@(posedge clk) disable iff (rst)
		eval && is_add && !subtract && add_shift == 5'h01
		&& op_a == 16'h00f0 && op_b == 16'h0000
		|=> result == 16'h0078)
		else $error("halving shift wrong");
	a_shift_twelve: assert property (@(posedge clk) disable iff (rst)
		eval && is_mul && mul_shift == 5'h0c && op_k == 16'h2000
		&& op_x == 16'h4000 |=> result == 16'h8000)
		else $error("post multiply shift wrong");
	a_mul_add: assert property (@(posedge clk) disable iff (rst)
		eval && is_mul_add && !subtract && mul_shift == 5'h00
		&& op_k == 16'h0003 && op_x == 16'h0004 && op_b == 16'h0064
		|=> result == 16'h0070)
		else $error("kx plus b wrong");
	a_add_mul: assert property (@(posedge clk) disable iff (rst)
		eval && is_add_mul && subtract && mul_shift == 5'h00
		&& op_a == 16'h0009 && op_b == 16'h0004 && op_k == 16'h0003
		|=> result == 16'h000f)
		else $error("difference times k wrong");
	a_narrow_slice: assert property (@(posedge clk) disable iff (rst)
		result_narrow == result[11:0])
		else $error("narrow slice wrong");
	a_bad_mode: assert property (@(posedge clk) disable iff (rst)
		eval && !mode_ok |=> !valid)
		else $error("invalid mode evaluated");
	a_valid_pulse: assert property (@(posedge clk) disable iff (rst)
		eval && mode_ok |=> valid)
		else $error("accepted eval gave no valid");
	a_valid_idle: assert property (@(posedge clk) disable iff (rst)
		!eval |=> !valid)
		else $error("valid without eval");
	a_reset_clear: assert property (@(posedge clk)
		rst |=> result == 16'h0000 && !valid)
		else $error("reset did not clear result");
	a_muladd_clamp: assert property (@(posedge clk) disable iff (rst)
		eval && is_mul_add && subtract && op_k == 16'h0000
		&& op_b != 16'h0000 |=> result == 16'h0000)
		else $error("kx minus b not clamped");
	a_addmul_sat: assert property (@(posedge clk) disable iff (rst)
		eval && is_add_mul && !subtract && mul_shift == 5'h00
		&& op_k == 16'hffff && op_a == 16'h0002 && op_b == 16'h0000
		|=> result == 16'hffff)
		else $error("sum times k not saturated");

	c_mul: cover property (@(posedge clk) eval && is_mul);
	c_sub_clamp: cover property (@(posedge clk)
		eval && is_add && subtract && op_a < op_b);
	c_mul_add: cover property (@(posedge clk) eval && is_mul_add);
	c_add_mul: cover property (@(posedge clk) eval && is_add_mul);
endmodule // unsigned_mul_add_core
`default_nettype wire
